// File: inc/idle_gating_regs.vh
// register map, field positions and reset values of the peripheral idle gating
// block; included by design files, holds definitions only.
//
// Behaviour
// RL1 - select register at 0x9400, bits 15-14 reserved
// RL2 - bit 13 gates miscellaneous group on idle
// RL3 - miscellaneous group: bus, timeout, clock registers
// RL4 - bit 12 gates external memory interface
// RL5 - bit 11 gates os tick timer
// RL6 - bit 10 gates watchdog timer
// RL7 - bit 9 gates parallel io port
// RL8 - bit 8 uart, bit 7 i2c
// RL9 - bit 6 gates identification module
// RL10 - bit 5 gates general-purpose io block
// RL11 - bits 4,3,2 gate serial ports 2,1,0
// RL12 - bit 1 gates timer one
// RL13 - bit 0 gates timer zero
// RL14 - idle with request clear wakes every peripheral
// RL15 - idle with request set wakes unselected peripherals
// RL16 - all select bits reset to zero
// RL17 - request bit idles only selected peripherals
// RL18 - status bit reports peripherals idled
// RL19 - reserved bits ignore writes, read zero
`ifndef IDLE_GATING_REGS_VH
`define IDLE_GATING_REGS_VH

// -------------------------------------------------------------------
// register offsets (byte addresses)
// -------------------------------------------------------------------
`define SELECT_ADDR 16'h9400
`define CONTROL_ADDR 16'h9404
`define STATUS_ADDR 16'h9408
`define GATE_ADDR 16'h940C

// -------------------------------------------------------------------
// fields
// -------------------------------------------------------------------
`define SEL_WIDTH 14
`define SEL_RESET 14'h0000
`define REQ_BIT 3
`define STAT_BIT 3
`define BIT_MISC 13
`define BIT_EXTMEM 12
`define BIT_TICK 11
`define BIT_WDOG 10
`define BIT_PPORT 9
`define BIT_UART 8
`define BIT_I2C 7
`define BIT_IDENT 6
`define BIT_GPIO 5
`define BIT_SPORT2 4
`define BIT_SPORT1 3
`define BIT_SPORT0 2
`define BIT_TIMER1 1
`define BIT_TIMER0 0

`endif

// File: design/sel_store.v
// holds the fourteen writable select bits.
// assumes write strobe and data come from the bus slave on the same clock.
`timescale 1ns/1ps
`include "idle_gating_regs.vh"
module sel_store #(
    parameter WIDTH = `SEL_WIDTH
) (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    output reg [WIDTH-1:0] q_r
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= `SEL_RESET; // RL16
        end else if (wr_en) begin
            q_r <= wr_data;
        end
    end
endmodule

// File: design/peripheral_idle_gating.v
// peripheral idle gating: select register, idle request/status and the
// per-peripheral gate outputs, reached over apb.
// assumes idle_exec is a one-cycle pulse from core logic on pclk.
// reset is asynchronous and active low; every gate starts low.
`timescale 1ns/1ps
`include "idle_gating_regs.vh"
module peripheral_idle_gating (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire idle_exec,
    output reg peripheral_idle_status,
    output reg misc_gate,
    output reg external_memory_gate,
    output reg os_tick_timer_gate,
    output reg watchdog_gate,
    output reg parallel_port_gate,
    output reg async_serial_gate,
    output reg i2c_gate,
    output reg identification_gate,
    output reg gpio_gate,
    output reg serial_port2_gate,
    output reg serial_port1_gate,
    output reg serial_port0_gate,
    output reg timer_one_gate,
    output reg timer_zero_gate
);
    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    function is_select;
        input [15:0] a;
        begin
            is_select = (a == `SELECT_ADDR);
        end
    endfunction

    function is_control;
        input [15:0] a;
        begin
            is_control = (a == `CONTROL_ADDR);
        end
    endfunction

    function is_status;
        input [15:0] a;
        begin
            is_status = (a == `STATUS_ADDR);
        end
    endfunction

    function is_gate_view;
        input [15:0] a;
        begin
            is_gate_view = (a == `GATE_ADDR);
        end
    endfunction

    function mapped;
        input [15:0] a;
        begin
            mapped = is_select(a) || is_control(a) || is_status(a) ||
                is_gate_view(a);
        end
    endfunction

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire setup = psel && !penable;
    // writes commit at the access edge, where the master samples pready
    wire access = psel && penable && pready;
    wire wr_sel = access && pwrite && is_select(paddr);
    wire wr_ctl = access && pwrite && is_control(paddr);
    wire [`SEL_WIDTH-1:0] sel_q;
    reg peripheral_idle_request_r;
    reg [`SEL_WIDTH-1:0] gate_r;
    reg [`SEL_WIDTH-1:0] gate_nxt;
    reg [31:0] rdata_nxt;

    // writes to bits 15-14 are dropped by taking only the low field
    sel_store #(
        .WIDTH(`SEL_WIDTH)
    ) u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_sel), // RL1 RL19
        .wr_data(pwdata[`SEL_WIDTH-1:0]),
        .q_r(sel_q)
    );

    // ---------------------------------------------------------------
    // idle request and gating
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_idle_request_r <= 1'b0;
        end else if (wr_ctl) begin
            peripheral_idle_request_r <= pwdata[`REQ_BIT];
        end
    end

    // gating only changes on an idle instruction; request clear wakes all
    // and request set re-evaluates every bit, so cleared bits wake
    always @* begin
        gate_nxt = gate_r;
        if (idle_exec) begin
            if (peripheral_idle_request_r) begin
                gate_nxt = sel_q; // RL17 RL15
            end else begin
                gate_nxt = {`SEL_WIDTH{1'b0}}; // RL14
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_r <= `SEL_RESET;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    // status only moves on an idle instruction, like the gates it reports
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_idle_status <= 1'b0;
        end else if (idle_exec) begin
            peripheral_idle_status <= peripheral_idle_request_r; // RL18
        end
    end

    // ---------------------------------------------------------------
    // gate outputs, one flip-flop each
    // ---------------------------------------------------------------
    // one gate serves the bus, timeout, timer select and clock regs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_gate <= 1'b0;
        end else begin
            misc_gate <= gate_nxt[`BIT_MISC]; // RL2 RL3
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_memory_gate <= 1'b0;
        end else begin
            external_memory_gate <= gate_nxt[`BIT_EXTMEM]; // RL4
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_tick_timer_gate <= 1'b0;
        end else begin
            os_tick_timer_gate <= gate_nxt[`BIT_TICK]; // RL5
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_gate <= 1'b0;
        end else begin
            watchdog_gate <= gate_nxt[`BIT_WDOG]; // RL6
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parallel_port_gate <= 1'b0;
        end else begin
            parallel_port_gate <= gate_nxt[`BIT_PPORT]; // RL7
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_serial_gate <= 1'b0;
        end else begin
            async_serial_gate <= gate_nxt[`BIT_UART]; // RL8
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2c_gate <= 1'b0;
        end else begin
            i2c_gate <= gate_nxt[`BIT_I2C]; // RL8
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            identification_gate <= 1'b0;
        end else begin
            identification_gate <= gate_nxt[`BIT_IDENT]; // RL9
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_gate <= 1'b0;
        end else begin
            gpio_gate <= gate_nxt[`BIT_GPIO]; // RL10
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_port2_gate <= 1'b0;
        end else begin
            serial_port2_gate <= gate_nxt[`BIT_SPORT2]; // RL11
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_port1_gate <= 1'b0;
        end else begin
            serial_port1_gate <= gate_nxt[`BIT_SPORT1]; // RL11
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_port0_gate <= 1'b0;
        end else begin
            serial_port0_gate <= gate_nxt[`BIT_SPORT0]; // RL11
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_gate <= 1'b0;
        end else begin
            timer_one_gate <= gate_nxt[`BIT_TIMER1]; // RL12
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_zero_gate <= 1'b0;
        end else begin
            timer_zero_gate <= gate_nxt[`BIT_TIMER0]; // RL13
        end
    end

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    // unused and reserved bits of every word read as zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (is_select(paddr)) begin
            rdata_nxt[`SEL_WIDTH-1:0] = sel_q; // RL19
        end else if (is_control(paddr)) begin
            rdata_nxt[`REQ_BIT] = peripheral_idle_request_r;
        end else if (is_status(paddr)) begin
            rdata_nxt[`STAT_BIT] = peripheral_idle_status;
        end else if (is_gate_view(paddr)) begin
            rdata_nxt[`SEL_WIDTH-1:0] = gate_r;
        end
    end

    // ---------------------------------------------------------------
    // apb answer: ready in the first access cycle
    // ---------------------------------------------------------------
    // no wait states: every setup cycle is answered in the next one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // unmapped accesses answer with an error; reads return zero, writes drop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped(paddr);
        end
    end

    // read data stand for the access cycle only and read zero otherwise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_nxt;
        end else begin
            prdata <= 32'h00000000;
        end
    end
endmodule

// File: testbench/idle_gating_chk_asserts.sv
// checker: apb answer and gate timing at the top ports.
// assumes binding into peripheral_idle_gating.
`timescale 1ns/1ps
module idle_gating_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire idle_exec,
    input wire peripheral_idle_status,
    input wire misc_gate,
    input wire timer_zero_gate
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_ERR: assert property (pslverr |-> paddr != 16'h9400)
        else $error("error on select");
    AST_RSV: assert property (
        pready && !pwrite && paddr == 16'h9400 |-> prdata[31:14] == 18'h0)
        else $error("reserved bits set");
    AST_HOLD: assert property (
        !idle_exec |=> $stable({misc_gate, timer_zero_gate}))
        else $error("gates moved");
    AST_WAKE: assert property (
        idle_exec ##1 !peripheral_idle_status |-> !misc_gate)
        else $error("not woken");
    AST_STAT: assert property (
        timer_zero_gate |-> peripheral_idle_status)
        else $error("status low");
    AST_RISE: assert property ($rose(misc_gate) |-> $past(idle_exec))
        else $error("gate without idle");
endmodule

// File: testbench/core_model.sv
// core side: issues the idle instruction pulse.
// assumes the bench calls idle from its own thread.
`timescale 1ns/1ps
module core_model (
    input wire pclk,
    output logic idle_exec
);
    initial idle_exec = 1'b0;
    // gap lets the core be prompt or slow between instructions
    task automatic idle(input int gap);
        repeat (gap + 1) @(posedge pclk);
        idle_exec <= 1'b1;
        @(posedge pclk);
        idle_exec <= 1'b0;
    endtask
endmodule

// File: testbench/tb.sv
// bench: register access and idle gating scenarios.
// assumes design files and core_model compiled first.
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, er;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, idle_exec, peripheral_idle_status, misc_gate;
    wire external_memory_gate, os_tick_timer_gate, watchdog_gate, i2c_gate;
    wire parallel_port_gate, async_serial_gate, identification_gate;
    wire gpio_gate, serial_port2_gate, serial_port1_gate, serial_port0_gate;
    wire timer_one_gate, timer_zero_gate;
    wire [13:0] g = {misc_gate, external_memory_gate, os_tick_timer_gate,
        watchdog_gate, parallel_port_gate, async_serial_gate, i2c_gate,
        identification_gate, gpio_gate, serial_port2_gate, serial_port1_gate,
        serial_port0_gate, timer_one_gate, timer_zero_gate};
    int miscompares = 0, num_checks = 0;
    always #5 pclk = ~pclk;
    peripheral_idle_gating u_dut (.*);
    core_model u_core (.pclk(pclk), .idle_exec(idle_exec));
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic xfer(input logic [15:0] a, input logic w,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input logic [31:0] sel, ctl, exp);
        xfer(16'h9400, 1'b1, sel);
        xfer(16'h9404, 1'b1, ctl);
        u_core.idle(sel[1:0]);
        #1;
        chk("gates", {18'h0, g}, exp);
        chk("status", 32'(peripheral_idle_status), 32'(ctl[3]));
    endtask
    task automatic t_reset;
        xfer(16'h9400, 1'b0, 32'h0);
        chk("select", rd, 32'h0);
        chk("mapped slverr", 32'(er), 32'h0);
        xfer(16'h9404, 1'b0, 32'h0);
        chk("request", rd, 32'h0);
        chk("gates", {18'h0, g}, 32'h0);
    endtask
    task automatic t_regs;
        xfer(16'h9400, 1'b1, 32'hFFFFFFFF);
        xfer(16'h9400, 1'b0, 32'h0);
        chk("select", rd, 32'h3FFF);
        xfer(16'h940C, 1'b0, 32'h0);
        chk("gate view", rd, 32'h0);
    endtask
    task automatic t_bits;
        for (int i = 0; i < 14; i++) begin
            run(32'h1 << i, 32'h8, 32'h1 << i);
        end
    endtask
    task automatic t_rst2;
        run(32'h3FFF, 32'h8, 32'h3FFF);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("reset gates", {18'h0, g}, 32'h0);
        chk("reset status", 32'(peripheral_idle_status), 32'h0);
        t_reset();
    endtask
    task automatic t_wake;
        run(32'h2001, 32'h8, 32'h2001);
        xfer(16'h9408, 1'b0, 32'h0);
        chk("status reg", rd, 32'h8);
        xfer(16'h9404, 1'b0, 32'h0);
        chk("request", rd, 32'h8);
        xfer(16'h9400, 1'b1, 32'h0);
        xfer(16'h940C, 1'b0, 32'h0);
        chk("gate view", rd, 32'h2001);
        chk("gates held", {18'h0, g}, 32'h2001);
        run(32'h0001, 32'h8, 32'h0001);
        run(32'h3FFF, 32'h0, 32'h0);
        xfer(16'h9404, 1'b0, 32'h0);
        chk("request", rd, 32'h0);
        xfer(16'h9408, 1'b0, 32'h0);
        chk("status reg", rd, 32'h0);
    endtask
    task automatic t_err;
        xfer(16'h9410, 1'b0, 32'h0);
        chk("slverr", {31'h0, er}, 32'h1);
        chk("unmapped", rd, 32'h0);
        xfer(16'h9400, 1'b1, 32'h0000C005);
        xfer(16'h9410, 1'b1, 32'h00003FFF);
        xfer(16'h940C, 1'b1, 32'h00003FFF);
        xfer(16'h9400, 1'b0, 32'h0);
        chk("select kept", rd, 32'h5);
        xfer(16'h940C, 1'b0, 32'h0);
        chk("gate view kept", rd, 32'h0);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_bits();
        t_rst2();
        t_wake();
        t_err();
        summarize();
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule
bind peripheral_idle_gating idle_gating_chk u_chk (.*);
